// *** flash_frame_if.sv ***
// Carrier between the serial link logic and the core status logic
`timescale 1ns/10ps
`default_nettype none
interface flash_frame_if;
  import flash_sr_pkg::*;
  logic [7:0] opcode;
  logic [2:0][7:0] arg;
  logic [2:0] byte_cnt;
  logic [2:0] bit_cnt;
  logic frame_tgl;
  logic so;
  logic so_oe_n;
  logic [STATUS_W-1:0] status_view;
  logic quad_en;
  logic read_en;
  modport link (output opcode, arg, byte_cnt, bit_cnt, frame_tgl, so,
    so_oe_n, input status_view, quad_en, read_en);
  modport core (input opcode, arg, byte_cnt, bit_cnt, frame_tgl, so,
    so_oe_n, output status_view, quad_en, read_en);
endinterface : flash_frame_if
`default_nettype wire

// *** flash_link_shifter.sv ***
// Serial clock side: command capture and status read-out
`timescale 1ns/10ps
`default_nettype none
module flash_link_shifter (
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_rstn,
  input wire logic i_si,
  input wire logic i_pause_n,
  flash_frame_if.link frame
);
  import flash_sr_pkg::*;
  logic armed_reg;
  logic tgl_reg;
  logic [2:0] bit_reg;
  logic [2:0] byte_reg;
  logic [6:0] shift_reg;
  logic [7:0] opcode_reg;
  logic [2:0][7:0] arg_reg;
  logic so_reg;
  logic so_oe_n_reg;
  logic hold_ok;
  logic reading;
  logic [2:0] bit_now;
  logic [2:0] byte_now;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;

  // Pause pin only counts while the pins are not data lines
  assign hold_ok = frame.quad_en | i_pause_n;
  assign bit_now = armed_reg ? 3'h0 : bit_reg;
  assign byte_now = armed_reg ? 3'h0 : byte_reg;
  assign byte_in = {shift_reg, i_si};
  assign reading = frame.read_en & ((opcode_reg == OPC_READ_SR1) |
    (opcode_reg == OPC_READ_SR2) | (opcode_reg == OPC_READ_SR3));
  assign rd_byte = (opcode_reg == OPC_READ_SR2) ? frame.status_view[15:8] :
    (opcode_reg == OPC_READ_SR3) ? frame.status_view[23:16] :
    frame.status_view[7:0];

  // Clock stops between frames, so the frame select restarts the counts
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) armed_reg <= 1'b1;
    else if (hold_ok) armed_reg <= 1'b0;
  end

  always_ff @(posedge i_sck or negedge i_rstn) begin
    if (!i_rstn) tgl_reg <= 1'b0;
    else if (armed_reg && hold_ok) tgl_reg <= ~tgl_reg;
  end

  always_ff @(posedge i_sck) begin
    if (hold_ok) begin
      shift_reg <= byte_in[6:0];
      bit_reg <= bit_now + 3'h1;
      if (bit_now == 3'h7 && byte_now != 3'h7) byte_reg <= byte_now + 3'h1;
      else byte_reg <= byte_now;
      if (bit_now == 3'h7 && byte_now == 3'h0) opcode_reg <= byte_in;
      for (int k = 0; k < 3; k++) begin
        if (bit_now == 3'h7 && byte_now == 3'(k + 1)) arg_reg[k] <= byte_in;
      end
    end
  end

  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      so_reg <= 1'b0;
      so_oe_n_reg <= 1'b1;
    end else if (armed_reg || !hold_ok) begin
      so_oe_n_reg <= 1'b1;
    end else if (byte_reg != 3'h0 && reading) begin
      so_reg <= rd_byte[3'h7 - bit_reg];
      so_oe_n_reg <= 1'b0;
    end
  end

  assign frame.opcode = opcode_reg;
  assign frame.arg = arg_reg;
  assign frame.byte_cnt = byte_reg;
  assign frame.bit_cnt = bit_reg;
  assign frame.frame_tgl = tgl_reg;
  assign frame.so = so_reg;
  assign frame.so_oe_n = so_oe_n_reg;
endmodule : flash_link_shifter
`default_nettype wire

// *** flash_sr_pkg.sv ***
// Constants and types shared by the flash status and write-protect block
// Behaviour
// - Busy flag reads 1 while program, erase or status write runs, else 0.
// - With the write latch clear, status write, program and erase are refused.
// - Five protect selectors are kept bits, changed only by status write.
// - Protect selectors accept new values only outside hardware status protection.
// - Full erase runs only for selectors 000 with invert 0, or 111 with 1.
// - Quad enable 0 makes pins write guard and pause; 1 makes them data.
// - Three security locks at bits 13 to 11 reset to 0, set independently.
// - A set security lock never clears; its register refuses program and erase. Reset here clears all three locks to 0.
// - Protect invert is a writable kept bit at 14, default 0.
// - Suspend sets erase paused (15) or program paused (10) by operation suspended.
// - Resume and power cycle clear both paused flags.
// - Drive strength code 00 full, 01 three quarters, 10 half, 11 quarter.
// - Guard bits 00: status writable whenever the write latch is set.
// - Guard bits 01: status locked while write guard pin is low.
// - Guard bits 10: status locked until power cycle, which returns guards 00.
// - In deep power-down every command except release is ignored.
// - Write enable sets latch; power-up, disable, writes, erases, reset clear it.
// - Quad-width commands are honoured only with quad enable set.
// - Status byte 0 holds busy, latch, selectors, guard low; guard high, quad 8, 9.
`default_nettype none
package flash_sr_pkg;
  localparam int STATUS_W = 24;
  localparam int BIT_WIP = 0;
  localparam int BIT_WEL = 1;
  localparam int SEL_LO = 2;
  localparam int SEL_HI = 6;
  localparam int BIT_GUARD_LO = 7;
  localparam int BIT_GUARD_HI = 8;
  localparam int BIT_QE = 9;
  localparam int BIT_PROG_PAUSED = 10;
  localparam int LOCK_LO = 11;
  localparam int LOCK_HI = 13;
  localparam int BIT_INVERT = 14;
  localparam int BIT_ERASE_PAUSED = 15;
  localparam int DRV_LO = 21;
  localparam int DRV_HI = 22;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 24'h000000;
  localparam logic [STATUS_W-1:0] WRITABLE_MASK = 24'h607bfc;
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_READ_SR1 = 8'h05;
  localparam logic [7:0] OPC_READ_SR2 = 8'h35;
  localparam logic [7:0] OPC_READ_SR3 = 8'h15;
  localparam logic [7:0] OPC_WRITE_SR1 = 8'h01;
  localparam logic [7:0] OPC_WRITE_SR2 = 8'h31;
  localparam logic [7:0] OPC_WRITE_SR3 = 8'h11;
  localparam logic [7:0] OPC_PROGRAM = 8'h02;
  localparam logic [7:0] OPC_QUAD_PROGRAM = 8'h32;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OPC_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OPC_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OPC_SEC_PROGRAM = 8'h42;
  localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
  localparam logic [7:0] OPC_SUSPEND = 8'h75;
  localparam logic [7:0] OPC_RESUME = 8'h7a;
  localparam logic [7:0] OPC_DEEP_DOWN = 8'hb9;
  localparam logic [7:0] OPC_RELEASE = 8'hab;
  localparam logic [7:0] OPC_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OPC_RESET = 8'h99;
  localparam logic [2:0] ADDR_BYTES = 3'h3;
  typedef enum logic [1:0] {
    BUSY_IDLE = 2'b00,
    BUSY_PROGRAM = 2'b01,
    BUSY_ERASE = 2'b10,
    BUSY_SR_WRITE = 2'b11
  } busy_kind_type;
endpackage : flash_sr_pkg
`default_nettype wire

// *** flash_status_write_protect.sv ***
// Status register, write protection and command filter of a serial flash
`timescale 1ns/10ps
`default_nettype none
module flash_status_write_protect #(
  parameter int CNT_W = 24,
  parameter int PROG_CYCLES = 1000,
  parameter int ERASE_CYCLES = 4000,
  parameter int CHIP_ERASE_CYCLES = 8000,
  parameter int SR_WRITE_CYCLES = 200
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_io2,
  input wire logic i_io3,
  output logic o_so,
  output logic o_so_oe_n,
  output logic o_io2,
  output logic o_io2_oe_n,
  output logic o_io3,
  output logic o_io3_oe_n,
  output logic [flash_sr_pkg::STATUS_W-1:0] o_status,
  output logic o_busy,
  output logic [1:0] o_drive_strength,
  output logic o_quad_mode,
  output logic o_deep_power_down,
  output logic o_op_start,
  output var flash_sr_pkg::busy_kind_type o_op_kind,
  output logic [23:0] o_op_addr,
  output logic o_cmd_refused
);
  import flash_sr_pkg::*;

  flash_frame_if frame ();

  flash_link_shifter u_link (
    .i_sck(i_sck),
    .i_cs_n(i_cs_n),
    .i_rstn(i_rstn),
    .i_si(i_si),
    .i_pause_n(i_io3),
    .frame(frame)
  );

  // Security register index 0 is not a register: treat it as locked
  function automatic logic sec_locked(input logic [2:0] locks,
                                      input logic [1:0] idx);
    sec_locked = (idx == 2'h0) ? 1'b1 : locks[idx - 2'h1];
  endfunction : sec_locked

  // Synchronisers for pins and the frame toggle
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_s3_reg;
  logic wp_s1_reg;
  logic wp_s2_reg;
  logic tg_s1_reg;
  logic tg_s2_reg;
  logic seen_reg;

  // Core state
  logic [STATUS_W-1:0] status_reg;
  logic [STATUS_W-1:0] status_next;
  busy_kind_type busy_reg;
  busy_kind_type busy_next;
  busy_kind_type saved_kind_reg;
  busy_kind_type saved_kind_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] saved_cnt_reg;
  logic [CNT_W-1:0] saved_cnt_next;
  logic dpd_reg;
  logic dpd_next;
  logic rst_en_reg;
  logic rst_en_next;
  logic [STATUS_W-1:0] view_reg;
  logic qe_view_reg;
  logic read_en_reg;
  logic op_start_reg;
  busy_kind_type op_kind_reg;
  busy_kind_type op_kind_next;
  logic [23:0] op_addr_reg;
  logic refused_reg;

  // Decode wires
  logic frame_end;
  logic cmd_valid;
  logic live;
  logic [7:0] opc;
  logic [2:0] n_args;
  logic [23:0] addr;
  logic idle;
  logic paused;
  logic write_latch_flag;
  logic qe;
  logic guard_lo;
  logic guard_hi;
  logic invert;
  logic [4:0] sel;
  logic [2:0] locks;
  logic wp_level;
  logic sr_hw_locked;
  logic sr_lockdown;
  logic is_sr;
  logic is_prog;
  logic is_erase;
  logic is_chip;
  logic is_sec_prog;
  logic is_sec_erase;
  logic write_class;
  logic chip_ok;
  logic sec_lock;
  logic gate;
  logic sr_go;
  logic prog_go;
  logic erase_go;
  logic refuse;
  logic suspend_go;
  logic resume_go;
  logic soft_reset;
  logic [STATUS_W-1:0] wr_data;
  logic [STATUS_W-1:0] wr_lanes;
  logic [STATUS_W-1:0] wr_mask;
  logic [STATUS_W-1:0] status_word;

  assign frame_end = cs_s2_reg & ~cs_s3_reg;
  // Link counts are stable here: the serial clock stops while deselected
  assign cmd_valid = frame_end & (tg_s2_reg != seen_reg) &
    (frame.bit_cnt == 3'h0) & (frame.byte_cnt != 3'h0);
  assign live = cmd_valid & ~dpd_reg;
  assign opc = frame.opcode;
  assign n_args = frame.byte_cnt - 3'h1;
  assign addr = {frame.arg[0], frame.arg[1], frame.arg[2]};

  assign idle = (busy_reg == BUSY_IDLE);
  assign paused = status_reg[BIT_ERASE_PAUSED] | status_reg[BIT_PROG_PAUSED];
  assign write_latch_flag = status_reg[BIT_WEL];
  assign qe = status_reg[BIT_QE];
  assign guard_lo = status_reg[BIT_GUARD_LO];
  assign guard_hi = status_reg[BIT_GUARD_HI];
  assign invert = status_reg[BIT_INVERT];
  assign sel = status_reg[SEL_HI:SEL_LO];
  assign locks = status_reg[LOCK_HI:LOCK_LO];

  // With quad enabled the guard pin carries data and no longer guards
  assign wp_level = qe | wp_s2_reg;
  assign sr_hw_locked = guard_lo & ~guard_hi & ~wp_level;
  // Both guards set is forbidden; it is held as locked, never as open
  assign sr_lockdown = guard_hi;

  assign is_sr = ((opc == OPC_WRITE_SR1) | (opc == OPC_WRITE_SR2) |
    (opc == OPC_WRITE_SR3)) & (n_args != 3'h0);
  assign is_prog = ((opc == OPC_PROGRAM) | ((opc == OPC_QUAD_PROGRAM) & qe))
    & (n_args > ADDR_BYTES);
  assign is_erase = ((opc == OPC_SECTOR_ERASE) | (opc == OPC_BLOCK32_ERASE) |
    (opc == OPC_BLOCK64_ERASE)) & (n_args == ADDR_BYTES);
  assign is_chip = ((opc == OPC_CHIP_ERASE_A) | (opc == OPC_CHIP_ERASE_B)) &
    (n_args == 3'h0);
  assign is_sec_prog = (opc == OPC_SEC_PROGRAM) & (n_args > ADDR_BYTES);
  assign is_sec_erase = (opc == OPC_SEC_ERASE) & (n_args == ADDR_BYTES);
  assign write_class = is_sr | is_prog | is_erase | is_chip | is_sec_prog |
    is_sec_erase;

  assign chip_ok = ((sel[2:0] == 3'h0) & ~invert) |
    ((sel[2:0] == 3'h7) & invert);
  assign sec_lock = sec_locked(locks, addr[13:12]);

  assign gate = live & write_latch_flag & idle & ~paused;
  assign sr_go = gate & is_sr & ~sr_hw_locked & ~sr_lockdown;
  assign prog_go = gate & (is_prog | (is_sec_prog & ~sec_lock));
  assign erase_go = gate & (is_erase | (is_chip & chip_ok) |
    (is_sec_erase & ~sec_lock));
  assign refuse = live & write_class & ~(sr_go | prog_go | erase_go);

  assign suspend_go = live & (opc == OPC_SUSPEND) &
    ((busy_reg == BUSY_PROGRAM) | (busy_reg == BUSY_ERASE));
  assign resume_go = live & (opc == OPC_RESUME) & paused;
  assign soft_reset = live & (opc == OPC_RESET) & rst_en_reg;

  // Byte lanes of a status write: first data byte is bits 7:0, 15:8 or 23:16 for SR1, SR2, SR3
  assign wr_data = (opc == OPC_WRITE_SR2) ? {8'h00, frame.arg[0], 8'h00} :
    (opc == OPC_WRITE_SR3) ? {frame.arg[0], 16'h0000} :
    {frame.arg[2], frame.arg[1], frame.arg[0]};
  assign wr_lanes = (opc == OPC_WRITE_SR2) ? 24'h00ff00 :
    (opc == OPC_WRITE_SR3) ? 24'hff0000 :
    (n_args == 3'h1) ? 24'h0000ff :
    (n_args == 3'h2) ? 24'h00ffff : 24'hffffff;
  // Busy, latch and paused flags are never taken from the host
  assign wr_mask = wr_lanes & WRITABLE_MASK;

  assign status_word = status_reg | ({{(STATUS_W-1){1'b0}}, ~idle}
    << BIT_WIP);

  always_comb begin
    status_next = status_reg;
    if (sr_go) begin
      status_next = (status_reg & ~wr_mask) | (wr_data & wr_mask);
      // Locks only ever gain bits
      status_next[LOCK_HI:LOCK_LO] = locks |
        (wr_data[LOCK_HI:LOCK_LO] & wr_mask[LOCK_HI:LOCK_LO]);
    end
    if (live && (write_class || opc == OPC_WRITE_DISABLE || soft_reset)) begin
      status_next[BIT_WEL] = 1'b0;
    end else if (live && opc == OPC_WRITE_ENABLE) begin
      status_next[BIT_WEL] = 1'b1;
    end
    if (suspend_go && busy_reg == BUSY_ERASE) begin
      status_next[BIT_ERASE_PAUSED] = 1'b1;
    end
    if (suspend_go && busy_reg == BUSY_PROGRAM) begin
      status_next[BIT_PROG_PAUSED] = 1'b1;
    end
    if (resume_go || soft_reset) begin
      status_next[BIT_ERASE_PAUSED] = 1'b0;
      status_next[BIT_PROG_PAUSED] = 1'b0;
    end
  end

  always_comb begin
    busy_next = busy_reg;
    cnt_next = cnt_reg;
    saved_kind_next = saved_kind_reg;
    saved_cnt_next = saved_cnt_reg;
    op_kind_next = BUSY_IDLE;
    if (busy_reg != BUSY_IDLE) begin
      if (cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) busy_next = BUSY_IDLE;
      else cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
    if (soft_reset) begin
      busy_next = BUSY_IDLE;
      saved_kind_next = BUSY_IDLE;
    end else if (suspend_go) begin
      saved_kind_next = busy_reg;
      saved_cnt_next = cnt_reg;
      busy_next = BUSY_IDLE;
    end else if (resume_go) begin
      busy_next = saved_kind_reg;
      cnt_next = saved_cnt_reg;
      saved_kind_next = BUSY_IDLE;
    end else if (sr_go) begin
      op_kind_next = BUSY_SR_WRITE;
      busy_next = BUSY_SR_WRITE;
      cnt_next = CNT_W'(SR_WRITE_CYCLES);
    end else if (prog_go) begin
      op_kind_next = BUSY_PROGRAM;
      busy_next = BUSY_PROGRAM;
      cnt_next = CNT_W'(PROG_CYCLES);
    end else if (erase_go) begin
      op_kind_next = BUSY_ERASE;
      busy_next = BUSY_ERASE;
      cnt_next = is_chip ? CNT_W'(CHIP_ERASE_CYCLES) : CNT_W'(ERASE_CYCLES);
    end
  end

  // Deep power-down is entered only when no operation runs
  assign dpd_next = dpd_reg ? ~(cmd_valid & (opc == OPC_RELEASE)) :
    (live & (opc == OPC_DEEP_DOWN) & idle & ~paused);
  // Reset must follow its enable directly, as the next command
  assign rst_en_next = cmd_valid ? (live & (opc == OPC_RESET_ENABLE)) :
    rst_en_reg;

  always_ff @(posedge i_core_clk) begin
    cs_s1_reg <= i_cs_n;
    cs_s2_reg <= cs_s1_reg;
    wp_s1_reg <= i_io2;
    wp_s2_reg <= wp_s1_reg;
    tg_s1_reg <= frame.frame_tgl;
    tg_s2_reg <= tg_s1_reg;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      cs_s3_reg <= 1'b1;
      seen_reg <= 1'b0;
    end else begin
      cs_s3_reg <= cs_s2_reg;
      if (frame_end) seen_reg <= tg_s2_reg;
    end
  end

  // Reset is the power cycle: it clears latch, pauses and lock-down
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      status_reg <= STATUS_RESET;
      busy_reg <= BUSY_IDLE;
      cnt_reg <= '0;
      saved_kind_reg <= BUSY_IDLE;
      saved_cnt_reg <= '0;
      dpd_reg <= 1'b0;
      rst_en_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      busy_reg <= busy_next;
      cnt_reg <= cnt_next;
      saved_kind_reg <= saved_kind_next;
      saved_cnt_reg <= saved_cnt_next;
      dpd_reg <= dpd_next;
      rst_en_reg <= rst_en_next;
    end
  end

  // Read-out copy changes only while deselected, so the link sees a
  // steady word; busy polling within one long frame will not update
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      view_reg <= STATUS_RESET;
      qe_view_reg <= 1'b0;
      read_en_reg <= 1'b1;
    end else if (cs_s2_reg) begin
      view_reg <= status_word;
      qe_view_reg <= qe;
      read_en_reg <= ~dpd_reg;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      op_start_reg <= 1'b0;
      op_kind_reg <= BUSY_IDLE;
      op_addr_reg <= 24'h000000;
      refused_reg <= 1'b0;
    end else begin
      op_start_reg <= sr_go | prog_go | erase_go;
      op_kind_reg <= op_kind_next;
      refused_reg <= refuse;
      if (prog_go || erase_go) op_addr_reg <= is_chip ? 24'h000000 : addr;
    end
  end

  assign frame.status_view = view_reg;
  assign frame.quad_en = qe_view_reg;
  assign frame.read_en = read_en_reg;

  assign o_so = frame.so;
  assign o_so_oe_n = frame.so_oe_n;
  // Quad data transfer lives elsewhere; these lines are never driven here
  assign o_io2 = 1'b0;
  assign o_io2_oe_n = 1'b1;
  assign o_io3 = 1'b0;
  assign o_io3_oe_n = 1'b1;
  assign o_status = status_word;
  assign o_busy = ~idle;
  assign o_drive_strength = status_reg[DRV_HI:DRV_LO];
  assign o_quad_mode = qe;
  assign o_deep_power_down = dpd_reg;
  assign o_op_start = op_start_reg;
  assign o_op_kind = op_kind_reg;
  assign o_op_addr = op_addr_reg;
  assign o_cmd_refused = refused_reg;
endmodule : flash_status_write_protect
`default_nettype wire

// *** flash_status_write_protect_props.sv ***
// Port-level checks on the flash status and write-protect block
`timescale 1ns/10ps
`default_nettype none
module flash_status_write_protect_props (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [flash_sr_pkg::STATUS_W-1:0] o_status,
  input wire logic o_busy,
  input wire logic [1:0] o_drive_strength,
  input wire logic o_quad_mode,
  input wire logic o_deep_power_down,
  input wire logic o_op_start,
  input var flash_sr_pkg::busy_kind_type o_op_kind,
  input wire logic o_cmd_refused
);
  import flash_sr_pkg::*;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  // Pulse rises on the execution edge with the status change; depth 2 samples two cycles back
  sequence s_latch_was_set;
    $past(o_status[BIT_WEL], 2) && !o_status[BIT_WEL] && o_busy;
  endsequence
  sequence s_word_held;
    o_status[23:2] == $past(o_status[23:2], 2) && !o_status[BIT_WEL];
  endsequence
  property p_busy_mirror;
    o_busy == o_status[BIT_WIP];
  endproperty
  property p_start;
    o_op_start |-> s_latch_was_set;
  endproperty
  property p_kind;
    o_op_start == (o_op_kind != BUSY_IDLE);
  endproperty
  property p_refused;
    o_cmd_refused |-> s_word_held;
  endproperty
  property p_lock;
    ($past(o_status[LOCK_HI:LOCK_LO]) & ~o_status[LOCK_HI:LOCK_LO]) == 3'h0;
  endproperty
  property p_lockdown;
    o_status[8:7] == 2'b10 |=>
      (o_status & WRITABLE_MASK) == $past(o_status & WRITABLE_MASK);
  endproperty
  property p_dpd;
    o_deep_power_down |-> !o_op_start && !o_cmd_refused;
  endproperty
  property p_mirror;
    o_quad_mode == o_status[BIT_QE] &&
      o_drive_strength == o_status[DRV_HI:DRV_LO];
  endproperty
  property p_pause;
    $rose(o_status[BIT_PROG_PAUSED] | o_status[BIT_ERASE_PAUSED])
      |-> $past(o_busy);
  endproperty
  a_busy_mirror: assert property (p_busy_mirror)
    else $error("busy differs from status bit 0");
  a_start: assert property (p_start)
    else $error("operation started without latch or busy");
  a_kind: assert property (p_kind)
    else $error("operation kind out of step with start");
  a_refused: assert property (p_refused)
    else $error("refused command changed status");
  a_lock: assert property (p_lock)
    else $error("security lock bit cleared");
  a_lockdown: assert property (p_lockdown)
    else $error("locked-down status changed");
  a_dpd: assert property (p_dpd)
    else $error("command acted on in deep power-down");
  a_mirror: assert property (p_mirror)
    else $error("quad or drive output differs from status");
  a_pause: assert property (p_pause)
    else $error("pause flag set while idle");
endmodule : flash_status_write_protect_props
`default_nettype wire

// *** flash_status_write_protect_tb_top.sv ***
// Self-checking bench for the flash status and write-protect block
`timescale 1ns/10ps
`default_nettype none
module flash_status_write_protect_tb_top;
  import flash_sr_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic io2_drv = 1'b1;
  logic io3_drv = 1'b1;
  wire logic i_sck, i_cs_n, i_si, i_io2, i_io3, o_so, o_so_oe_n, o_io2;
  wire logic o_io2_oe_n, o_io3, o_io3_oe_n, o_busy, o_quad_mode;
  wire logic o_deep_power_down, o_op_start, o_cmd_refused;
  wire logic [STATUS_W-1:0] o_status;
  wire logic [1:0] o_drive_strength;
  wire logic [23:0] o_op_addr;
  busy_kind_type o_op_kind;
  busy_kind_type last_kind;
  logic [23:0] exp_sr;
  logic [7:0] rx;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_start = 0;
  int n_ref = 0;
  int s0 = 0;
  int r0 = 0;
  always #12.5 i_core_clk = ~i_core_clk;
  assign i_io2 = o_io2_oe_n ? io2_drv : o_io2;
  assign i_io3 = o_io3_oe_n ? io3_drv : o_io3;
  // Released output line shows the inverse of its last bit
  spi_host_model spi_host_model_inst (.o_sck(i_sck), .o_cs_n(i_cs_n),
    .o_si(i_si), .i_so(o_so_oe_n ? ~o_so : o_so));
  flash_status_write_protect #(.PROG_CYCLES(100), .ERASE_CYCLES(100),
    .CHIP_ERASE_CYCLES(100), .SR_WRITE_CYCLES(20))
    flash_status_write_protect_inst (.i_core_clk, .i_rstn, .i_sck, .i_cs_n,
    .i_si, .i_io2, .i_io3, .o_so, .o_so_oe_n, .o_io2, .o_io2_oe_n, .o_io3,
    .o_io3_oe_n, .o_status, .o_busy, .o_drive_strength, .o_quad_mode,
    .o_deep_power_down, .o_op_start, .o_op_kind, .o_op_addr,
    .o_cmd_refused);
  // Pulses are counted away from the edge that launches them
  always @(negedge i_core_clk) begin
    cycles++;
    if (o_op_start === 1'b1) begin
      n_start++;
      last_kind = o_op_kind;
    end
    if (o_cmd_refused === 1'b1)
      n_ref++;
    if (cycles == 40000) begin
      failures++;
      complete_run();
    end
  end
  function automatic logic [23:0] sr_next(logic [23:0] s, logic [23:0] d);
    return (s & ~WRITABLE_MASK) | (d & WRITABLE_MASK) | (s & 24'h003800);
  endfunction : sr_next
  task automatic complete_run;
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [23:0] got, input logic [23:0] want);
    comparisons++;
    if (got !== want) begin
      failures++;
      $display("ERROR %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic fr(input logic [7:0] q[$]);
    @(posedge i_core_clk);
    #2;
    spi_host_model_inst.xfer(q, rx);
  endtask : fr
  task automatic idle;
    for (int i = 0; i < 300 && o_busy !== 1'b0; i++) begin
      @(posedge i_core_clk);
      #2;
    end
    chk({23'h0, o_busy}, 24'h0);
  endtask : idle
  task automatic pulses(input int s, input int r);
    chk(24'(n_start - s0), 24'(s));
    chk(24'(n_ref - r0), 24'(r));
    s0 = n_start;
    r0 = n_ref;
  endtask : pulses
  task automatic pwr;
    @(posedge i_core_clk);
    #2;
    i_rstn = 1'b0;
    repeat (4) @(posedge i_core_clk);
    #2;
    i_rstn = 1'b1;
    repeat (4) @(posedge i_core_clk);
    #2;
    exp_sr = 24'h0;
    chk(o_status, exp_sr);
  endtask : pwr
  task automatic wr(input logic [23:0] d);
    logic ok;
    ok = !(exp_sr[8] || (exp_sr[7] && !io2_drv));
    fr('{OPC_WRITE_ENABLE});
    chk(o_status, exp_sr | 24'h2);
    fr('{OPC_WRITE_SR1, d[7:0], d[15:8], d[23:16]});
    idle();
    if (ok)
      exp_sr = sr_next(exp_sr, d);
    chk(o_status, exp_sr);
    pulses(ok, !ok);
    fr('{OPC_READ_SR1, 8'h00});
    chk({16'h0, rx}, {16'h0, exp_sr[7:0]});
  endtask : wr
  initial begin
    logic [23:0] d;
    exp_sr = 24'h0;
    void'($urandom(50));
    repeat (20) @(posedge i_core_clk);
    #2;
    i_rstn = 1'b1;
    repeat (4) @(posedge i_core_clk);
    #2;
    chk(o_status, 24'h0);
    fr('{OPC_WRITE_SR1, 8'h1c});
    chk(o_status, 24'h0);
    pulses(0, 1);
    for (int i = 0; i < 12; i++) begin
      d = 24'($urandom);
      d[8] = 1'b0;
      d[13:11] = 3'h0;
      d[22:21] = i[1:0];
      wr(d);
      chk({22'h0, o_drive_strength}, {22'h0, exp_sr[22:21]});
      chk({23'h0, o_quad_mode}, {23'h0, exp_sr[BIT_QE]});
    end
    wr(24'h000080);
    io2_drv = 1'b0;
    wr(24'h00001c);
    io2_drv = 1'b1;
    wr(24'h00001c);
    for (int i = 0; i < 4; i++) begin
      wr({9'h0, i[1], 9'h0, {3{i[0]}}, 2'h0});
      fr('{OPC_WRITE_ENABLE});
      fr('{i[0] ? OPC_CHIP_ERASE_A : OPC_CHIP_ERASE_B});
      idle();
      chk(o_status, exp_sr);
      pulses(i[0] == i[1], i[0] != i[1]);
    end
    fr('{OPC_WRITE_ENABLE});
    fr('{OPC_PROGRAM, 8'h12, 8'h34, 8'h56, 8'ha5});
    chk(o_op_addr, 24'h123456);
    chk({23'h0, o_busy}, 24'h1);
    fr('{OPC_SUSPEND});
    chk(o_status, exp_sr | 24'h000400);
    fr('{OPC_RESUME});
    chk(o_status, exp_sr | 24'h000001);
    idle();
    chk({22'h0, last_kind}, {22'h0, BUSY_PROGRAM});
    fr('{OPC_WRITE_ENABLE});
    fr('{OPC_SECTOR_ERASE, 8'h00, 8'h10, 8'h00});
    fr('{OPC_SUSPEND});
    chk(o_status, exp_sr | 24'h008000);
    pulses(2, 0);
    pwr();
    wr(24'h000100);
    wr(24'h00001c);
    pwr();
    wr(24'h000800);
    wr(24'h000000);
    for (int i = 1; i < 3; i++) begin
      fr('{OPC_WRITE_ENABLE});
      fr('{OPC_SEC_ERASE, 8'h00, 8'(i << 4), 8'h00});
      idle();
      pulses(i - 1, 2 - i);
    end
    fr('{OPC_DEEP_DOWN});
    fr('{OPC_WRITE_ENABLE});
    fr('{OPC_CHIP_ERASE_A});
    pulses(0, 0);
    // Output stays released in power-down, so the line reads inverted
    fr('{OPC_READ_SR1, 8'h00});
    chk({16'h0, rx}, 24'h0000ff);
    chk({23'h0, o_deep_power_down}, 24'h1);
    chk(o_status, exp_sr);
    fr('{OPC_RELEASE});
    fr('{OPC_WRITE_ENABLE});
    chk(o_status, exp_sr | 24'h2);
    fr('{OPC_WRITE_DISABLE});
    chk(o_status, exp_sr);
    fr('{OPC_WRITE_ENABLE});
    fr('{OPC_RESET_ENABLE});
    fr('{OPC_RESET});
    chk(o_status, exp_sr);
    for (int i = 0; i < 2; i++) begin
      wr({14'h0, i[0], 9'h0});
      fr('{OPC_WRITE_ENABLE});
      fr('{OPC_QUAD_PROGRAM, 8'h00, 8'h01, 8'h00, 8'h3c});
      chk(o_status, exp_sr | {22'h0, ~i[0], i[0]});
      pulses(i, 0);
      idle();
    end
    fr('{OPC_WRITE_ENABLE});
    fr('{OPC_WRITE_SR3, 8'h40});
    idle();
    exp_sr[22:21] = 2'h2;
    chk(o_status, exp_sr);
    pulses(1, 0);
    fr('{OPC_READ_SR3, 8'h00});
    chk({16'h0, rx}, {16'h0, exp_sr[23:16]});
    fr('{OPC_READ_SR2, 8'h00});
    chk({16'h0, rx}, {16'h0, exp_sr[15:8]});
    complete_run();
  end
endmodule : flash_status_write_protect_tb_top
bind flash_status_write_protect flash_status_write_protect_props props_inst (
  .i_core_clk, .i_rstn, .o_status, .o_busy, .o_drive_strength, .o_quad_mode,
  .o_deep_power_down, .o_op_start, .o_op_kind, .o_cmd_refused);
`default_nettype wire

// *** spi_host_model.sv ***
// Serial host model that clocks command frames into the flash block
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so
);
  // Mode 0: clock stands low outside frames
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  task automatic xfer(input logic [7:0] q[$], output logic [7:0] rx);
    rx = 8'h00;
    o_cs_n = 1'b0;
    #32;
    foreach (q[i]) begin
      for (int b = 7; b >= 0; b--) begin
        o_si = q[i][b];
        #32;
        o_sck = 1'b1;
        rx = {rx[6:0], i_so};
        #32;
        o_sck = 1'b0;
      end
    end
    // Released line flips so a stale bit is never mistaken for data
    o_si = ~o_si;
    #32;
    o_cs_n = 1'b1;
    #250;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire
